// file: src/gpio_expander_defines.vh
`ifndef GPIO_EXPANDER_DEFINES_VH
`define GPIO_EXPANDER_DEFINES_VH

// Register addresses (eight-bit register address space)
`define ADDR_IFACE_CFG_A     8'h00
`define ADDR_IFACE_CFG_B     8'h01
`define ADDR_PIN_DIR         8'h40
`define ADDR_PIN_VALUE       8'h41
`define ADDR_FAULT_CTRL      8'h42
`define ADDR_FAULT_SRC_SEL   8'h43

// Reset values
`define RST_IFACE_CFG_A      8'h18
`define RST_IFACE_CFG_B      8'h80
`define RST_PIN_DIR          8'h00
`define RST_PIN_VALUE        8'h00
`define RST_FAULT_CTRL       8'h00
`define RST_FAULT_SRC_SEL    8'h00

// Fault control field positions
`define FCTL_OUT_EN_BIT      0
`define FCTL_IN_EN_BIT       1
`define FCTL_IN_STATUS_BIT   2

// Pin positions of the fault functions
`define PIN_FAULT_OUT        7
`define PIN_FAULT_IN         6

`endif

// file: src/pin_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for a vector of pin levels
module pin_sync #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // Levels
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

// file: src/gpio_expander.v
`timescale 1ns/100ps
`include "gpio_expander_defines.vh"

module gpio_expander #(
   parameter NUM_PINS = 8,
   parameter NUM_ERR  = 8
) (
   // Clock and reset
   input  wire                clk_sys,
   input  wire                rst_n,
   // Mode: high when the device is under serial control, low when strapped
   input  wire                serial_mode,
   // Register access from the serial interface decoder
   input  wire                reg_wr,
   input  wire                reg_rd,
   input  wire [7:0]          reg_addr,
   input  wire [7:0]          reg_wdata,
   output reg  [7:0]          reg_rdata_r,
   output reg                 reg_ack_r,
   output reg                 reg_err_r,
   // Diagnostic error levels
   input  wire [NUM_ERR-1:0]  diag_err,
   // General pins, split into input, output and output enable
   input  wire [NUM_PINS-1:0] pin_in,
   output reg  [NUM_PINS-1:0] pin_out_r,
   output reg  [NUM_PINS-1:0] pin_oe_r
);

   // Registers
   reg [7:0]          cfg_a_r;
   reg [7:0]          cfg_b_r;
   reg [NUM_PINS-1:0] dir_r;
   reg [NUM_PINS-1:0] value_r;
   reg                fault_out_en_r;
   reg                fault_in_en_r;
   reg                fault_in_stat_r;
   reg [NUM_ERR-1:0]  src_sel_r;

   wire [NUM_PINS-1:0] pin_sync_w;
   wire                fault_or_w;
   wire                diag_hit_w;
   reg  [7:0]          rdata_nxt;
   reg                 hit_nxt;
   reg                 wr_cfg_a;
   reg                 wr_cfg_b;
   reg                 wr_dir;
   reg                 wr_value;
   reg                 wr_fctl;
   reg                 wr_src_sel;

   // Pin levels cross into the clock domain first
   pin_sync #(
      .WIDTH (NUM_PINS)
   ) u_pin_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (pin_in),
      .sync_out (pin_sync_w)
   );

   // Address decode shared by read and write
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `ADDR_IFACE_CFG_A) || (a == `ADDR_IFACE_CFG_B) ||
                     (a == `ADDR_PIN_DIR) || (a == `ADDR_PIN_VALUE) ||
                     (a == `ADDR_FAULT_CTRL) || (a == `ADDR_FAULT_SRC_SEL);
      end
   endfunction

   // Selected diagnostic errors, any one of them raises the fault
   assign diag_hit_w = |(diag_err & src_sel_r);

   // External fault status joins the selected errors
   assign fault_or_w = diag_hit_w | fault_in_stat_r;

   // Write decode; a write to an unmapped address selects nothing
   always @* begin
      wr_cfg_a   = 1'b0;
      wr_cfg_b   = 1'b0;
      wr_dir     = 1'b0;
      wr_value   = 1'b0;
      wr_fctl    = 1'b0;
      wr_src_sel = 1'b0;
      if (reg_wr) begin
         if (reg_addr == `ADDR_IFACE_CFG_A) begin
            wr_cfg_a = 1'b1;
         end else if (reg_addr == `ADDR_IFACE_CFG_B) begin
            wr_cfg_b = 1'b1;
         end else if (reg_addr == `ADDR_PIN_DIR) begin
            wr_dir = 1'b1;
         end else if (reg_addr == `ADDR_PIN_VALUE) begin
            wr_value = 1'b1;
         end else if (reg_addr == `ADDR_FAULT_CTRL) begin
            wr_fctl = 1'b1;
         end else if (reg_addr == `ADDR_FAULT_SRC_SEL) begin
            wr_src_sel = 1'b1;
         end
      end
   end

   // Interface configuration A, plain storage
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_a_r <= `RST_IFACE_CFG_A;
      end else if (wr_cfg_a) begin
         cfg_a_r <= reg_wdata;
      end
   end

   // Interface configuration B, plain storage
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_b_r <= `RST_IFACE_CFG_B;
      end else if (wr_cfg_b) begin
         cfg_b_r <= reg_wdata;
      end
   end

   // Direction register, a set bit makes its pin an output
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         dir_r <= `RST_PIN_DIR;
      end else if (wr_dir) begin
         dir_r <= reg_wdata[NUM_PINS-1:0];
      end
   end

   // Pin value register, driven onto output pins
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         value_r <= `RST_PIN_VALUE;
      end else if (wr_value) begin
         value_r <= reg_wdata[NUM_PINS-1:0];
      end
   end

   // Fault control enables; the status bit is read-only
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         fault_out_en_r <= 1'b0;
         fault_in_en_r  <= 1'b0;
      end else if (wr_fctl) begin
         fault_out_en_r <= reg_wdata[`FCTL_OUT_EN_BIT];
         fault_in_en_r  <= reg_wdata[`FCTL_IN_EN_BIT];
      end
   end

   // Fault source select, bit n picks diagnostic error n
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         src_sel_r <= `RST_FAULT_SRC_SEL;
      end else if (wr_src_sel) begin
         src_sel_r <= reg_wdata[NUM_ERR-1:0];
      end
   end

   // External fault input status follows synchronised pin six
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         fault_in_stat_r <= 1'b0;
      end else begin
         fault_in_stat_r <= fault_in_en_r & serial_mode &
                            pin_sync_w[`PIN_FAULT_IN];
      end
   end

   // Read mux: input pins show pin level, output pins show value
   always @* begin
      rdata_nxt = 8'h00;
      hit_nxt   = is_mapped(reg_addr);
      if (reg_addr == `ADDR_IFACE_CFG_A) begin
         rdata_nxt = cfg_a_r;
      end else if (reg_addr == `ADDR_IFACE_CFG_B) begin
         rdata_nxt = cfg_b_r;
      end else if (reg_addr == `ADDR_PIN_DIR) begin
         rdata_nxt[NUM_PINS-1:0] = dir_r;
      end else if (reg_addr == `ADDR_PIN_VALUE) begin
         rdata_nxt[NUM_PINS-1:0] = (dir_r & value_r) | (~dir_r & pin_sync_w);
      end else if (reg_addr == `ADDR_FAULT_CTRL) begin
         rdata_nxt[`FCTL_OUT_EN_BIT]    = fault_out_en_r;
         rdata_nxt[`FCTL_IN_EN_BIT]     = fault_in_en_r;
         rdata_nxt[`FCTL_IN_STATUS_BIT] = fault_in_stat_r;
      end else if (reg_addr == `ADDR_FAULT_SRC_SEL) begin
         rdata_nxt[NUM_ERR-1:0] = src_sel_r;
      end
   end

   // Read answer one cycle after the request
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata_r <= 8'h00;
         reg_ack_r   <= 1'b0;
         reg_err_r   <= 1'b0;
      end else begin
         reg_ack_r   <= reg_rd | reg_wr;
         reg_err_r   <= (reg_rd | reg_wr) & ~hit_nxt;
         reg_rdata_r <= reg_rd ? rdata_nxt : reg_rdata_r;
      end
   end

   // Pin drivers; pin seven is taken over by the fault output
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
         always @(posedge clk_sys) begin
            if (!rst_n) begin
               pin_out_r[g] <= 1'b0;
               pin_oe_r[g]  <= 1'b0;
            end else if (!serial_mode) begin
               pin_out_r[g] <= 1'b0;
               pin_oe_r[g]  <= 1'b0;
            end else if ((g == `PIN_FAULT_OUT) && fault_out_en_r) begin
               pin_out_r[g] <= fault_or_w;
               pin_oe_r[g]  <= 1'b1;
            end else begin
               pin_out_r[g] <= value_r[g];
               pin_oe_r[g]  <= dir_r[g];
            end
         end
      end
   endgenerate

endmodule

// file: sim/gpio_expander_props.sv
`timescale 1ns/100ps
// Port checker for pin, fault and strap behaviour
module gpio_expander_props (
   // Clock, reset and mode
   input logic       clk_sys,
   input logic       rst_n,
   input logic       serial_mode,
   // Register access
   input logic       reg_wr,
   input logic       reg_rd,
   input logic       reg_ack_r,
   input logic       reg_err_r,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic [7:0] reg_rdata_r,
   // Errors and pins
   input logic [7:0] diag_err,
   input logic [7:0] pin_in,
   input logic [7:0] pin_out_r,
   input logic [7:0] pin_oe_r
);
   logic [1:0] fen_r;
   logic [7:0] sel_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Shadow copies of the fault enables and source select
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fen_r <= 2'b00;
         sel_r <= 8'h00;
      end else if (reg_wr && reg_addr == 8'h42) begin
         fen_r <= reg_wdata[1:0];
      end else if (reg_wr && reg_addr == 8'h43) begin
         sel_r <= reg_wdata;
      end
   end
   AST_STRAP: assert property (
      !serial_mode && !$past(serial_mode) |-> (pin_oe_r | pin_out_r) == 8'h00) else $error("strap");
   AST_DIR: assert property (
      reg_wr && reg_addr == 8'h40 && serial_mode ##1 !reg_wr && serial_mode
      |=> pin_oe_r[6:0] == $past(reg_wdata[6:0], 2)) else $error("direction");
   AST_OUT: assert property (
      reg_wr && reg_addr == 8'h41 && serial_mode ##1 !reg_wr && serial_mode
      |=> ((pin_out_r ^ $past(reg_wdata, 2)) & pin_oe_r & 8'h7f) == 8'h00) else $error("value");
   AST_FOUT_EN: assert property (
      reg_wr && reg_addr == 8'h42 && reg_wdata[0] && serial_mode ##1 !reg_wr && serial_mode
      |=> pin_oe_r[7]) else $error("fault enable");
   AST_FSEL: assert property (
      (serial_mode && fen_r[0] && |(diag_err & sel_r))[*3] |-> pin_out_r[7]) else $error("fault or");
   AST_FIN_PASS: assert property (
      (serial_mode && fen_r == 2'b11 && pin_in[6])[*6] |-> pin_out_r[7]) else $error("fault pass");
   AST_FIN_READ: assert property (
      (serial_mode && fen_r[1] && pin_in[6])[*5] ##0 (reg_rd && reg_addr == 8'h42)
      |=> reg_rdata_r[2]) else $error("fault status");
   AST_READ_IN: assert property (
      ($stable(pin_in) && serial_mode && !reg_wr)[*4] ##0 (reg_rd && reg_addr == 8'h41)
      |=> ((reg_rdata_r ^ $past(pin_in)) & ~$past(pin_oe_r) & 8'h7f) == 8'h00) else $error("input");
endmodule
bind gpio_expander gpio_expander_props chk (
   .clk_sys     (clk_sys),
   .rst_n       (rst_n),
   .serial_mode (serial_mode),
   .reg_wr      (reg_wr),
   .reg_rd      (reg_rd),
   .reg_ack_r   (reg_ack_r),
   .reg_err_r   (reg_err_r),
   .reg_addr    (reg_addr),
   .reg_wdata   (reg_wdata),
   .reg_rdata_r (reg_rdata_r),
   .diag_err    (diag_err),
   .pin_in      (pin_in),
   .pin_out_r   (pin_out_r),
   .pin_oe_r    (pin_oe_r)
);

// file: sim/pin_periph.sv
`timescale 1ns/100ps
// Peripheral circuits: drive each pin that the expander leaves released
module pin_periph (
   // Expander pin drive
   input  logic [7:0] pin_out_r,
   input  logic [7:0] pin_oe_r,
   // Levels the peripheral circuits put on released pins
   input  logic [7:0] ext_val,
   // Level seen on each pin
   output logic [7:0] level
);
   assign level = (pin_oe_r & pin_out_r) | (~pin_oe_r & ext_val);
endmodule

// file: sim/test_spi_gpio_expander_err_pin.sv
`timescale 1ns/100ps
// Table-driven register checks, then fault, strap and reset cases
module test_spi_gpio_expander_err_pin;
   logic       clk_sys = 0, rst_n = 0, serial_mode = 1, reg_wr = 0, reg_rd = 0;
   logic       reg_ack_r, reg_err_r, er;
   logic [7:0] reg_addr = 0, reg_wdata = 0, diag_err = 0, ext_val = 8'h30;
   logic [7:0] reg_rdata_r, pin_out_r, pin_oe_r, pin_in, rd;
   int         n_fail = 0, tests_run = 0, i;
   // Rows: error flag (bit 25), write flag (bit 24), address, data, expected read
   logic [27:0] rows [11] = '{28'h000_0018, 28'h001_0080, 28'h040_0000, 28'h043_0000,
      28'h140_0f00, 28'h040_000f, 28'h141_a500, 28'h041_0035, 28'h143_3c00, 28'h043_003c,
      28'h27f_0000};
   gpio_expander dut (.clk_sys, .rst_n, .serial_mode, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata_r, .reg_ack_r, .reg_err_r, .diag_err, .pin_in, .pin_out_r, .pin_oe_r);
   pin_periph far_end (.pin_out_r, .pin_oe_r, .ext_val, .level(pin_in));
   always #4 clk_sys = ~clk_sys;
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One register access, ack waited for under a bound
   task automatic bus(input logic w, input logic [7:0] a, d);
      int k;
      @(posedge clk_sys);
      #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      @(posedge clk_sys);
      #1 {reg_wr, reg_rd} = 2'b00;
      for (k = 0; k < 4 && reg_ack_r !== 1'b1; k++) begin
         @(posedge clk_sys);
         #1;
      end
      if (reg_ack_r !== 1'b1) begin
         n_fail++;
         complete_run();
      end else begin
         rd = reg_rdata_r;
         er = reg_err_r;
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1;
      for (i = 0; i < 11; i++) begin
         bus(rows[i][24], rows[i][23:16], rows[i][15:8]);
         if (!rows[i][24]) chk(rd, rows[i][7:0]);
         chk(er, rows[i][25]);
      end
      chk(pin_oe_r, 8'h0f);
      chk(pin_out_r & 8'h0f, 8'h05);
      $display("register table done");
      bus(1, 8'h42, 8'h01);
      diag_err = 8'h04;
      repeat (4) @(posedge clk_sys);
      #1 chk({pin_oe_r[7], pin_out_r[7]}, 8'h03);
      diag_err = 8'h01;
      repeat (4) @(posedge clk_sys);
      #1 chk(pin_out_r[7], 8'h00);
      ext_val = 8'h70;
      bus(1, 8'h42, 8'h03);
      repeat (6) @(posedge clk_sys);
      bus(0, 8'h42, 8'h00);
      chk(rd, 8'h07);
      chk(pin_out_r[7], 8'h01);
      bus(0, 8'h41, 8'h00);
      chk(rd, 8'hf5);
      $display("fault pin done");
      serial_mode = 0;
      repeat (2) @(posedge clk_sys);
      #1 chk(pin_oe_r | pin_out_r, 8'h00);
      bus(0, 8'h42, 8'h00);
      chk(rd, 8'h03);
      serial_mode = 1;
      repeat (2) @(posedge clk_sys);
      #1 chk(pin_oe_r, 8'h8f);
      rst_n = 0;
      @(posedge clk_sys);
      #1 chk(pin_oe_r | pin_out_r, 8'h00);
      rst_n = 1;
      bus(0, 8'h40, 8'h00);
      chk(rd, 8'h00);
      $display("strap and reset done");
      complete_run();
   end
endmodule
